// ### verilog/aiw_regs.svh
`ifndef AIW_REGS_SVH
`define AIW_REGS_SVH

// ---------------------------------------------------------------
// instruction field positions
// ---------------------------------------------------------------
`define AIW_DST_HI 15
`define AIW_DST_LO 11
`define AIW_OPC_HI 10
`define AIW_OPC_LO 5
`define AIW_SRC_HI 4
`define AIW_SRC_LO 0
`define AIW_IMM_HI 31
`define AIW_IMM_LO 16

// ---------------------------------------------------------------
// opcode values
// ---------------------------------------------------------------
`define AIW_OPC_ADD_IMMEDIATE 6'h30
`define AIW_OPC_AND_REGISTER 6'h0A
`define AIW_OPC_AND_IMM 6'h36

// ---------------------------------------------------------------
// widths, sizes and reset values
// ---------------------------------------------------------------
`define AIW_WORD_MSB 31
`define AIW_EXT_W 16
`define AIW_NUM_REGS 32
`define AIW_WORD_ZERO 32'h0000_0000
`define AIW_HALF_ZERO 16'h0000

`endif

// ### verilog/aiw_pkg.sv
package aiw_pkg;

   // status word bits touched by this slice
   typedef struct packed {
      logic carryFlag;
      logic signedWrapFlag;
      logic negativeFlag;
      logic zeroFlag;
      logic clampStickyFlag;
   } aiw_flags_type;

   // decoded operation, one-hot
   typedef enum logic [3:0] {
      AIW_OP_NONE = 4'h1,
      AIW_OP_ADD_IMMEDIATE = 4'h2,
      AIW_OP_AND_REGISTER = 4'h4,
      AIW_OP_AND_IMM = 4'h8
   } aiw_op_type;

endpackage

// ### verilog/aiw_alu.sv
// Operation
// - add immediate writes source plus extended immediate
// - immediate sign-extended; source register left intact unless it is also the destination
// - register and: destination gets destination AND source
// - register and clears wrap, sets negative, zero
// - and immediate: source AND zero-extended immediate
// - and immediate clears wrap, sets negative, zero
// - and immediate zero-extends; source register intact unless it is also the destination
// - upper field destination, lower field source, immediate
`timescale 1ns/1ps
`default_nettype none
`include "aiw_regs.svh"

module aiw_alu
   import aiw_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic instrValid,
   input wire logic [`AIW_WORD_MSB:0] instrWord,
   input wire logic loadEn,
   input wire logic [4:0] loadAddr,
   input wire logic [`AIW_WORD_MSB:0] loadData,
   input wire logic flagLoadEn,
   input wire aiw_flags_type flagLoadData,
   input wire logic [4:0] readAddr,
   output logic [`AIW_WORD_MSB:0] readData,
   output logic [`AIW_WORD_MSB:0] resultData_q,
   output logic resultValid_q,
   output logic illegalOp_q,
   output aiw_flags_type flags_q
);

   // ---------------------------------------------------------------
   // general register file and decode
   // ---------------------------------------------------------------
   logic [`AIW_WORD_MSB:0] generalRegisterFile [`AIW_NUM_REGS];
   logic [4:0] sourceRegisterField;
   logic [4:0] destinationRegisterField;
   logic [5:0] opcodeField;
   logic [15:0] immediateHalfword;
   logic [`AIW_WORD_MSB:0] srcVal;
   logic [`AIW_WORD_MSB:0] dstVal;
   logic [`AIW_WORD_MSB:0] signExtImm;
   logic [`AIW_WORD_MSB:0] zeroExtImm;
   logic [`AIW_WORD_MSB+1:0] addSum;
   logic [`AIW_WORD_MSB:0] result_d;
   aiw_op_type opKind;
   aiw_flags_type flags_d;
   logic doExec;

   // field extraction
   assign destinationRegisterField = instrWord[`AIW_DST_HI:`AIW_DST_LO];
   assign sourceRegisterField = instrWord[`AIW_SRC_HI:`AIW_SRC_LO];
   assign opcodeField = instrWord[`AIW_OPC_HI:`AIW_OPC_LO];
   assign immediateHalfword = instrWord[`AIW_IMM_HI:`AIW_IMM_LO];
   assign srcVal = generalRegisterFile[sourceRegisterField];
   assign dstVal = generalRegisterFile[destinationRegisterField];
   assign readData = generalRegisterFile[readAddr];

   // immediate extension
   assign signExtImm = {{`AIW_EXT_W{immediateHalfword[`AIW_IMM_HI-`AIW_IMM_LO]}},
      immediateHalfword};
   assign zeroExtImm = {`AIW_HALF_ZERO, immediateHalfword};
   assign addSum = {1'b0, srcVal} + {1'b0, signExtImm};

   // opcode decode
   always_comb begin
      if (opcodeField == `AIW_OPC_ADD_IMMEDIATE) begin
         opKind = AIW_OP_ADD_IMMEDIATE;
      end else if (opcodeField == `AIW_OPC_AND_REGISTER) begin
         opKind = AIW_OP_AND_REGISTER;
      end else if (opcodeField == `AIW_OPC_AND_IMM) begin
         opKind = AIW_OP_AND_IMM;
      end else begin
         opKind = AIW_OP_NONE;
      end
   end

   assign doExec = instrValid && (opKind != AIW_OP_NONE);

   // ---------------------------------------------------------------
   // result and flag computation
   // ---------------------------------------------------------------
   always_comb begin
      result_d = `AIW_WORD_ZERO;
      flags_d = flags_q;
      unique case (opKind)
         AIW_OP_ADD_IMMEDIATE: begin
            result_d = addSum[`AIW_WORD_MSB:0];
            flags_d.carryFlag = addSum[`AIW_WORD_MSB+1];
            flags_d.signedWrapFlag = (srcVal[`AIW_WORD_MSB] == signExtImm[`AIW_WORD_MSB])
               && (addSum[`AIW_WORD_MSB] != srcVal[`AIW_WORD_MSB]);
         end
         AIW_OP_AND_REGISTER: begin
            result_d = dstVal & srcVal;
            flags_d.signedWrapFlag = 1'b0;
         end
         AIW_OP_AND_IMM: begin
            result_d = srcVal & zeroExtImm;
            flags_d.signedWrapFlag = 1'b0;
         end
         AIW_OP_NONE: begin
            result_d = `AIW_WORD_ZERO;
         end
      endcase
      if (opKind != AIW_OP_NONE) begin
         flags_d.negativeFlag = result_d[`AIW_WORD_MSB];
         flags_d.zeroFlag = (result_d == `AIW_WORD_ZERO);
      end
   end

   // ---------------------------------------------------------------
   // register file write: execution wins over the load port
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int k = 0; k < `AIW_NUM_REGS; k++) begin
            generalRegisterFile[k] <= `AIW_WORD_ZERO;
         end
      end else if (doExec) begin
         generalRegisterFile[destinationRegisterField] <= result_d;
      end else if (loadEn) begin
         generalRegisterFile[loadAddr] <= loadData;
      end
   end

   // status word, carry and clamp kept by the and operations
   always_ff @(posedge clk) begin
      if (rst) begin
         flags_q <= '0;
      end else if (instrValid && doExec) begin
         flags_q <= flags_d;
      end else if (flagLoadEn) begin
         flags_q <= flagLoadData;
      end
   end

   // result observation and illegal opcode pulse
   always_ff @(posedge clk) begin
      if (rst) begin
         resultData_q <= `AIW_WORD_ZERO;
         resultValid_q <= 1'b0;
         illegalOp_q <= 1'b0;
      end else begin
         resultValid_q <= doExec;
         illegalOp_q <= instrValid && !doExec;
         if (doExec) begin
            resultData_q <= result_d;
         end
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sequence s_addIssue;
      instrValid && opcodeField == `AIW_OPC_ADD_IMMEDIATE;
   endsequence

   sequence s_andRegIssue;
      instrValid && opcodeField == `AIW_OPC_AND_REGISTER;
   endsequence

   sequence s_andImmIssue;
      instrValid && opcodeField == `AIW_OPC_AND_IMM;
   endsequence

   property p_add_sum;
      @(posedge clk) disable iff (rst)
      s_addIssue |=> resultValid_q && resultData_q == $past(srcVal) + $past(signExtImm);
   endproperty
   a_add_sum: assert property (p_add_sum) else $error("add immediate sum wrong");

   property p_add_sext;
      @(posedge clk) disable iff (rst)
      s_addIssue ##0 (destinationRegisterField != sourceRegisterField)
         |=> resultData_q - $past(srcVal)
            == {{`AIW_EXT_W{$past(immediateHalfword[`AIW_IMM_HI-`AIW_IMM_LO])}},
               $past(immediateHalfword)};
   endproperty
   a_add_sext: assert property (p_add_sext) else $error("immediate not sign extended");

   property p_src_kept;
      @(posedge clk) disable iff (rst)
      (s_addIssue or s_andImmIssue) ##0 (destinationRegisterField != sourceRegisterField)
         |=> generalRegisterFile[$past(sourceRegisterField)] == $past(srcVal);
   endproperty
   a_src_kept: assert property (p_src_kept) else $error("source register changed");

   property p_add_flags;
      @(posedge clk) disable iff (rst)
      s_addIssue |=> flags_q.carryFlag == $past(addSum[`AIW_WORD_MSB+1])
         && flags_q.clampStickyFlag == $past(flags_q.clampStickyFlag)
         && flags_q.zeroFlag == (resultData_q == `AIW_WORD_ZERO);
   endproperty
   a_add_flags: assert property (p_add_flags) else $error("add flags wrong");

   property p_and_reg;
      @(posedge clk) disable iff (rst)
      s_andRegIssue |=> resultData_q == ($past(dstVal) & $past(srcVal));
   endproperty
   a_and_reg: assert property (p_and_reg) else $error("register and result wrong");

   property p_and_flags;
      @(posedge clk) disable iff (rst)
      (s_andRegIssue or s_andImmIssue) |=> !flags_q.signedWrapFlag
         && flags_q.negativeFlag == resultData_q[`AIW_WORD_MSB]
         && $stable(flags_q.carryFlag) && $stable(flags_q.clampStickyFlag);
   endproperty
   a_and_flags: assert property (p_and_flags) else $error("and flags wrong");

   property p_and_imm;
      @(posedge clk) disable iff (rst)
      s_andImmIssue |=> resultData_q == ($past(srcVal) & {`AIW_HALF_ZERO, $past(immediateHalfword)})
         && resultData_q[`AIW_WORD_MSB:`AIW_IMM_LO] == `AIW_HALF_ZERO;
   endproperty
   a_and_imm: assert property (p_and_imm) else $error("and immediate result wrong");

   property p_dst_written;
      @(posedge clk) disable iff (rst)
      doExec |=> generalRegisterFile[$past(destinationRegisterField)] == resultData_q;
   endproperty
   a_dst_written: assert property (p_dst_written) else $error("destination not written");

endmodule
`default_nettype wire

// ### bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "aiw_regs.svh"

module tb_top
   import aiw_pkg::*;
   ;
   // ---------------------------------------------------------------
   // signals and model state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic ill;
      logic [31:0] res;
      aiw_flags_type fl;
   } aiw_exp_type;

   logic clk = 1'h0;
   logic rst = 1'h1;
   logic instrValid = 1'h0;
   logic loadEn = 1'h0;
   logic flagLoadEn = 1'h0;
   logic [31:0] instrWord = 32'h0;
   logic [31:0] loadData = 32'h0;
   logic [4:0] loadAddr = 5'h0;
   logic [4:0] readAddr = 5'h0;
   logic collide = 1'h0;
   logic [31:0] lastRes = 32'h0;
   aiw_flags_type flagLoadData = 5'h0;
   logic [31:0] readData, resultData_q;
   logic resultValid_q, illegalOp_q;
   aiw_flags_type flags_q;
   aiw_flags_type fm = 5'h0;
   logic [31:0] rm [32];
   aiw_exp_type q[$];
   logic [5:0] ops [4] = '{6'h30, 6'h0A, 6'h36, 6'h01};
   int errorCnt = 0;
   int nChecks = 0;

   // clock toggles every half period
   always #4 clk = ~clk;

   aiw_alu dut_u (.clk(clk), .rst(rst), .instrValid(instrValid), .instrWord(instrWord),
      .loadEn(loadEn), .loadAddr(loadAddr), .loadData(loadData), .flagLoadEn(flagLoadEn),
      .flagLoadData(flagLoadData), .readAddr(readAddr), .readData(readData),
      .resultData_q(resultData_q), .resultValid_q(resultValid_q),
      .illegalOp_q(illegalOp_q), .flags_q(flags_q));

   // ---------------------------------------------------------------
   // compare and report
   // ---------------------------------------------------------------
   task automatic fail(string m);
      errorCnt++;
      $display("mismatch at %0t: %s", $time, m);
   endtask

   task automatic cmpW(logic [31:0] e, logic [31:0] g, string m);
      nChecks++;
      if (g !== e) fail(m);
   endtask

   task automatic cmpF(aiw_flags_type e, aiw_flags_type g);
      nChecks++;
      if (g !== e) fail("flags");
   endtask

   task automatic summarize();
      $display("errors %0d checks %0d", errorCnt, nChecks);
      if (errorCnt == 0 && nChecks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // drivers, updating the reference model
   // ---------------------------------------------------------------
   task automatic load(logic [4:0] a, logic [31:0] v);
      instrValid = 1'h0;
      flagLoadEn = 1'h0;
      loadEn = 1'h1;
      loadAddr = a;
      loadData = v;
      rm[a] = v;
      @(negedge clk);
   endtask

   task automatic setf(aiw_flags_type f);
      instrValid = 1'h0;
      loadEn = 1'h0;
      flagLoadEn = 1'h1;
      flagLoadData = f;
      fm = f;
      @(negedge clk);
   endtask

   // leaves instrValid high so calls run back to back
   task automatic exec(logic [5:0] op, logic [4:0] d, logic [4:0] s, logic [15:0] im);
      logic [32:0] sum;
      aiw_exp_type e;
      e.ill = 1'h0;
      e.fl = fm;
      e.res = lastRes;
      case (op)
         `AIW_OPC_ADD_IMMEDIATE: begin
            sum = {1'h0, rm[s]} + {1'h0, {16{im[15]}}, im};
            e.res = sum[31:0];
            e.fl.carryFlag = sum[32];
            e.fl.signedWrapFlag = (rm[s][31] == im[15]) && (sum[31] != im[15]);
         end
         `AIW_OPC_AND_REGISTER: begin
            e.res = rm[d] & rm[s];
            e.fl.signedWrapFlag = 1'h0;
         end
         `AIW_OPC_AND_IMM: begin
            e.res = rm[s] & {16'h0, im};
            e.fl.signedWrapFlag = 1'h0;
         end
         default: e.ill = 1'h1;
      endcase
      if (!e.ill) begin
         e.fl.negativeFlag = e.res[31];
         e.fl.zeroFlag = (e.res == 32'h0);
         rm[d] = e.res;
         fm = e.fl;
         lastRes = e.res;
      end
      q.push_back(e);
      loadEn = collide;
      flagLoadEn = collide;
      loadAddr = d;
      loadData = ~e.res;
      flagLoadData = ~e.fl;
      instrValid = 1'h1;
      instrWord = {im, d, op, s};
      @(negedge clk);
   endtask

   // ---------------------------------------------------------------
   // output monitor, oldest note first
   // ---------------------------------------------------------------
   always @(negedge clk) begin : mon
      aiw_exp_type e;
      if (resultValid_q === 1'h1 || illegalOp_q === 1'h1) begin
         if (q.size() == 0) fail("unexpected result");
         else begin
            e = q.pop_front();
            cmpW({31'h0, e.ill}, {31'h0, illegalOp_q}, "illegal pulse");
            cmpW(e.res, resultData_q, "result");
            cmpF(e.fl, flags_q);
         end
      end
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      void'($urandom(32'hD8B1C582));
      repeat (4) @(negedge clk);
      rst = 1'h0;
      #1 cmpW(32'h0, readData, "reset value");
      cmpW(32'h0, resultData_q, "reset result");
      cmpW(32'h0, {30'h0, resultValid_q, illegalOp_q}, "reset pulses");
      cmpF(5'h0, flags_q);
      @(negedge clk);
      for (int i = 0; i < 32; i++) load(i[4:0], $urandom);
      setf(5'h1F);
      load(5'h1, 32'h7FFFFFFF);
      exec(6'h30, 5'h2, 5'h1, 16'h0001);
      load(5'h3, 32'hFFFFFFFF);
      exec(6'h30, 5'h4, 5'h3, 16'h0001);
      exec(6'h30, 5'h5, 5'h3, 16'h8000);
      exec(6'h36, 5'h6, 5'h3, 16'h8000);
      exec(6'h0A, 5'h6, 5'h4, 16'hFFFF);
      exec(6'h3F, 5'h7, 5'h3, 16'h1234);
      collide = 1'h1;
      exec(6'h30, 5'h8, 5'h3, 16'h0002);
      collide = 1'h0;
      for (int i = 0; i < 200; i++) begin
         if ($urandom % 8 == 0) setf(5'($urandom));
         exec(ops[$urandom % 4], 5'($urandom), 5'($urandom), 16'($urandom));
      end
      instrValid = 1'h0;
      repeat (2) @(negedge clk);
      for (int i = 0; i < 32; i++) begin
         readAddr = i[4:0];
         #1 cmpW(rm[i], readData, "register");
         @(negedge clk);
      end
      cmpW(32'h0, 32'(q.size()), "missing result");
      summarize();
   end

   // watchdog against a hang
   initial begin
      #20000;
      fail("timeout");
      summarize();
   end
endmodule
`default_nettype wire
